// ---- verilog/adc_output_port.sv ----
// Purpose: output side of an oversampling converter with parallel read bus
// Assumes: sync_n is the documented digital reset; clock free-running
// Notes:   bus pins are split into output and enable for the bench
//
// Contract
// - one modulator sample taken every conversion clock cycle
// - decimate by six; one output word every six clocks
// - strobe high three clocks, low three clocks
// - each result is a 16-bit parallel word
// - output word forced to zero while sync is low
// - output word zero for at most 21 strobe cycles after sync release
// - words valid 55 strobe cycles after sync release; host ignores earlier
// - range flag rises when input exceeds convertible range
// - power-down low stops conversion and cuts activity
// - falling strobe edge announces each new word
// - bus driven only while chip-select and read-enable both low
// - range flag updates only on falling strobe edge
// - sync low clears logic, strobe high; low at second rising edge after
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module adc_output_port
(
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    input  wire logic                   sync_n,
    input  wire logic                   power_down_n,
    input  wire logic signed [3:0]      mod_sample,
    input  adc_port_pkg::host_read_t    host_rd,
    output logic                        word_ready_strobe_n,
    output logic                        range_overflow_flag,
    output logic [15:0]                 data_out,
    output logic                        data_oe,
    output logic                        settled
);
    import adc_port_pkg::*;

    // ****************************************************************
    // reset
    // ****************************************************************
    logic [1:0] rst_sync;
    logic       rst_n;
    logic       clr_n;

    // two-stage release; sync_n joins as a second asynchronous clear
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];
    assign clr_n = rst_n & sync_n;

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [2:0] pd_sync;
    logic [2:0] cs_sync;
    logic [2:0] rd_sync;
    logic       pd_q;
    logic       cs_q;
    logic       rd_q;

    // three stages; a change counts when stages two and three agree
    // sync clears them too, so the enable and power state restart idle
    always_ff @(posedge core_clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            pd_sync <= 3'b111;
            cs_sync <= 3'b111;
            rd_sync <= 3'b111;
        end
        else
        begin
            pd_sync <= {pd_sync[1:0], power_down_n};
            cs_sync <= {cs_sync[1:0], host_rd.cs_n};
            rd_sync <= {rd_sync[1:0], host_rd.rd_n};
        end
    end

    always_ff @(posedge core_clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            pd_q <= 1'b1;
            cs_q <= 1'b1;
            rd_q <= 1'b1;
        end
        else
        begin
            if (pd_sync[1] == pd_sync[2])
                pd_q <= pd_sync[2];
            if (cs_sync[1] == cs_sync[2])
                cs_q <= cs_sync[2];
            if (rd_sync[1] == rd_sync[2])
                rd_q <= rd_sync[2];
        end
    end

    // ****************************************************************
    // strobe phase
    // ****************************************************************
    strobe_phase_t phase;
    logic [2:0]    phase_cnt;
    logic          active;
    logic          fall;

    // power-down freezes the sequencer so the filter stops toggling
    assign active = pd_q;
    assign fall   = active && phase == PH_HIGH && phase_cnt == `STROBE_HIGH_CYC - 3'd1;

    // reset phase lasts one edge so the strobe falls on the second edge
    always_ff @(posedge core_clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            phase     <= PH_RESET;
            phase_cnt <= 3'd0;
        end
        else if (active)
        begin
            unique case (phase)
                PH_RESET:
                begin
                    phase     <= PH_HIGH;
                    phase_cnt <= `STROBE_HIGH_CYC - 3'd1;
                end
                PH_HIGH:
                begin
                    if (phase_cnt == `STROBE_HIGH_CYC - 3'd1)
                    begin
                        phase     <= PH_LOW;
                        phase_cnt <= 3'd0;
                    end
                    else
                        phase_cnt <= phase_cnt + 3'd1;
                end
                PH_LOW:
                begin
                    // three low then three high make one six-clock word
                    if (phase_cnt == `DECIM_FACTOR - `STROBE_HIGH_CYC - 3'd1)
                    begin
                        phase     <= PH_HIGH;
                        phase_cnt <= 3'd0;
                    end
                    else
                        phase_cnt <= phase_cnt + 3'd1;
                end
                default:
                begin
                    phase     <= PH_RESET;
                    phase_cnt <= 3'd0;
                end
            endcase
        end
    end

    // strobe from a flop: high in reset and high phase
    always_ff @(posedge core_clk or negedge clr_n)
    begin
        if (!clr_n)
            word_ready_strobe_n <= 1'b1;
        else
            word_ready_strobe_n <= !(fall || (phase == PH_LOW && !(active
                && phase_cnt == `DECIM_FACTOR - `STROBE_HIGH_CYC - 3'd1)));
    end

    // ****************************************************************
    // filter and output word
    // ****************************************************************
    sample_t filt;
    logic    dump;

    // dump one cycle before the fall so the word lands while strobe is high
    assign dump = active && phase == PH_HIGH && phase_cnt == `STROBE_HIGH_CYC - 3'd2;

    // frozen sequencer feeds zeros so the accumulator neither toggles nor wraps
    logic signed [3:0] mod_in;
    assign mod_in = active ? mod_sample : 4'sd0;

    decimator u_decim
    (
        .clk        (core_clk),
        .rst_n      (clr_n),
        .mod_sample (mod_in),
        .dump       (dump),
        .result     (filt)
    );

    logic [15:0] word;

    // word and flag latched together at the falling strobe edge
    always_ff @(posedge core_clk or negedge clr_n)
    begin
        if (!clr_n)
            word <= 16'h0000;
        else if (fall)
            word <= filt.word;
    end

    // flag sets on overrange and clears on return, only at the fall
    always_ff @(posedge core_clk or negedge clr_n)
    begin
        if (!clr_n)
            range_overflow_flag <= 1'b0;
        else if (fall)
            range_overflow_flag <= filt.over;
    end

    // ****************************************************************
    // settling count
    // ****************************************************************
    logic [5:0] word_cnt;

    // counts strobe cycles since release; the first word lands well under 21
    always_ff @(posedge core_clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            word_cnt <= 6'd0;
            settled  <= 1'b0;
        end
        else if (fall && !settled)
        begin
            word_cnt <= word_cnt + 6'd1;
            if (word_cnt == `SETTLE_WORDS - 6'd1)
                settled <= 1'b1;
        end
    end

    // ****************************************************************
    // read bus
    // ****************************************************************
    // drive only with both selects low; the word itself is held stable
    always_ff @(posedge core_clk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            data_out <= 16'h0000;
            data_oe  <= 1'b0;
        end
        else
        begin
            data_out <= (fall ? filt.word : word);
            data_oe  <= !cs_q && !rd_q;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_high3;
        word_ready_strobe_n [*3];
    endsequence

    a_strobe_low_three: assert property (@(posedge core_clk) disable iff (!clr_n || !active)
        $fell(word_ready_strobe_n) |-> !word_ready_strobe_n [*3] ##1 s_high3)
        else $error("strobe low or high phase not three cycles");

    a_word_on_fall: assert property (@(posedge core_clk) disable iff (!clr_n)
        !word_ready_strobe_n && $past(!word_ready_strobe_n) |-> $stable(data_out))
        else $error("output word changed during low phase");

    a_flag_on_fall: assert property (@(posedge core_clk) disable iff (!clr_n)
        $changed(range_overflow_flag) |-> $fell(word_ready_strobe_n))
        else $error("range flag changed away from strobe fall");

    a_bus_enable: assert property (@(posedge core_clk) disable iff (!clr_n)
        data_oe == $past(!cs_q && !rd_q))
        else $error("bus enable does not follow selects");

    a_period_six: assert property (@(posedge core_clk) disable iff (!clr_n || !active)
        $fell(word_ready_strobe_n) |-> ##6 $fell(word_ready_strobe_n))
        else $error("word period not six clocks");

    a_first_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(clr_n) && active |-> ##2 !word_ready_strobe_n)
        else $error("strobe not low at second edge after release");

    a_settled_count: assert property (@(posedge core_clk) disable iff (!clr_n)
        $rose(settled) |-> word_cnt == `SETTLE_WORDS)
        else $error("settled raised at wrong strobe count");

    a_overflow_clip: assert property (@(posedge core_clk) disable iff (!clr_n)
        fall && filt.over |=> range_overflow_flag &&
        (data_out == `FULL_POS || data_out == `FULL_NEG))
        else $error("overrange word not clipped and flagged");
endmodule : adc_output_port

// ---- common/adc_port_defines.svh ----
// Purpose: constants for the decimating converter output port
// Assumes: one conversion clock, 20 MHz in this build
// Notes:   counts are in conversion clock cycles or word periods
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH

`define DECIM_FACTOR      3'd6
`define STROBE_HIGH_CYC   3'd3
`define ZERO_WORDS_MAX    6'd21
`define SETTLE_WORDS      6'd55
`define WORD_WIDTH        16
`define FULL_POS          16'h7fff
`define FULL_NEG          16'h8000
`define MOD_MAX           3'd6

`endif

// ---- common/adc_port_pkg.sv ----
// Purpose: shared types for the converter output port
// Assumes: constants live in adc_port_defines.svh
// Notes:   none
package adc_port_pkg;
    // host read strobes, both active low
    typedef struct packed {
        logic cs_n;
        logic rd_n;
    } host_read_t;

    // one output word with its range flag
    typedef struct packed {
        logic        over;
        logic [15:0] word;
    } sample_t;

    typedef enum logic [2:0] {
        PH_RESET = 3'b001,
        PH_HIGH  = 3'b010,
        PH_LOW   = 3'b100
    } strobe_phase_t;
endpackage : adc_port_pkg

// ---- verilog/decimator.sv ----
// Purpose: sums six modulator samples into one clipped 16-bit word
// Assumes: modulator delivers a signed 4-bit level each clock
// Notes:   boxcar stands in for the real filter coefficients
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module decimator
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic signed [3:0]      mod_sample,
    input  wire logic                   dump,
    output adc_port_pkg::sample_t       result
);
    import adc_port_pkg::*;

    logic signed [7:0] acc;
    logic signed [7:0] next_acc;

    // clip a wide sum into the 16-bit two's complement range
    function automatic sample_t clip(input logic signed [19:0] v);
        sample_t s;
        s.over = 1'b0;
        s.word = v[15:0];
        if (v > 20'sd32767)
        begin
            s.over = 1'b1;
            s.word = `FULL_POS;
        end
        else if (v < -20'sd32768)
        begin
            s.over = 1'b1;
            s.word = `FULL_NEG;
        end
        return s;
    endfunction : clip

    assign next_acc = acc + 8'(mod_sample);

    // one sample every clock
    // the dump sample already sits in the result, so the next window starts empty
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            acc <= 8'sd0;
        else if (dump)
            acc <= 8'sd0;
        else
            acc <= next_acc;
    end

    // scale so that six full-level samples pass full scale
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            result <= '0;
        else if (dump)
            result <= clip(20'(next_acc) <<< 12);
    end
endmodule : decimator

// ---- tb/host_reader.sv ----
// Purpose: host model that reads words off the parallel output bus
// Assumes: the bench requests the selects; a word is taken mid-period
// Notes:   a released bus shows the inverse of its last value
`timescale 1ns/100ps
module host_reader
(
    input  wire logic                clk,
    input  wire logic [1:0]          sel_req,
    input  wire logic                strobe_n,
    input  wire logic [15:0]         data_out,
    input  wire logic                data_oe,
    output adc_port_pkg::host_read_t host_rd,
    output logic [15:0]              got
);
    import adc_port_pkg::*;
    logic [15:0] last;
    logic [15:0] bus;
    logic [2:0]  age;

    // selects stay low across words, so the synchroniser lag costs nothing
    assign host_rd = sel_req;
    // an undriven bus never repeats the old word by chance
    assign bus = data_oe ? data_out : ~last;

    // word taken two edges after the fall, well inside its stand time
    always_ff @(posedge clk)
    begin
        if (data_oe)
            last <= data_out;
        age <= strobe_n ? 3'd0 : age + 3'd1;
        if (!strobe_n && age == 3'd1)
            got <= bus;
    end
endmodule : host_reader

// ---- tb/test_decimating_adc_output_port.sv ----
// Purpose: self-checking bench for the converter output port
// Assumes: a level held for several periods makes each word predictable
// Notes:   random levels come from a fixed-seed shift register
`timescale 1ns/100ps
`include "adc_port_defines.svh"
module test_decimating_adc_output_port;
    import adc_port_pkg::*;
    logic              core_clk = 1'b0;
    logic              nrst = 1'b0;
    logic              sync_n = 1'b0;
    logic              power_down_n = 1'b1;
    logic signed [3:0] mod_sample = 4'sh1;
    logic [1:0]        sel_req = 2'b11;
    host_read_t        host_rd;
    logic              strobe_n, over, oe, settled, s;
    logic              was_low = 1'b0;
    logic [15:0]       data_out, got, prev, w;
    logic [15:0]       seed = 16'hd591;
    int                n_errors = 0;
    int                n_compared = 0;
    int                k, v, nfall, first_nz;
    int                corner[5] = '{2, -2, 0, -1, 1};

    always #25 core_clk = ~core_clk;

    adc_output_port u_dut
    (
        .core_clk(core_clk), .nrst(nrst), .sync_n(sync_n),
        .power_down_n(power_down_n), .mod_sample(mod_sample), .host_rd(host_rd),
        .word_ready_strobe_n(strobe_n), .range_overflow_flag(over),
        .data_out(data_out), .data_oe(oe), .settled(settled)
    );

    host_reader u_host
    (
        .clk(core_clk), .sel_req(sel_req), .strobe_n(strobe_n),
        .data_out(data_out), .data_oe(oe), .host_rd(host_rd), .got(got)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    // boxcar of six equal levels, clipped with the range flag
    function automatic logic [16:0] expect_word(input int lvl);
        int sum;
        sum = 6 * lvl * 4096;
        if (sum > 32767)
            return {1'b1, `FULL_POS};
        if (sum < -32768)
            return {1'b1, `FULL_NEG};
        return {1'b0, sum[15:0]};
    endfunction : expect_word

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic cmp(input logic [16:0] act, input logic [16:0] exp, input string what);
        n_compared++;
        if (act !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: %s", $time, what);
        end
    endtask : cmp

    task automatic summarize();
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // clear with sync, then follow the strobe cadence until the filter settles
    task automatic resync(input int lvl);
        sync_n = 1'b0;
        mod_sample = 4'(lvl);
        cyc(2);
        cmp(17'(data_out), 17'h0, "word not cleared");
        cmp(17'(strobe_n), 17'h1, "strobe not forced high");
        sync_n = 1'b1;
        cyc(1);
        cmp(17'(strobe_n), 17'h1, "strobe fell early");
        nfall = 0;
        first_nz = 0;
        for (k = 0; k < 336; k++)
        begin
            cyc(1);
            nfall += (k % 6 == 0);
            cmp(17'(strobe_n), 17'(k % 6 >= 3), "strobe cadence");
            if (k % 6 == 5)
                cmp(17'(settled), 17'(nfall >= 55), "settle count");
            if (data_out !== 16'h0 && first_nz == 0)
                first_nz = nfall;
        end
        cmp(17'(first_nz > 0 && first_nz <= 21), 17'h1, "zero words too long");
    endtask : resync

    // the word may only move at the fall, so it stands through the low phase
    always @(negedge core_clk)
    begin
        // a sync clear zeroes the word on purpose, so it ends the low-phase watch
        if (was_low && strobe_n === 1'b0 && sync_n)
            cmp(17'(data_out), 17'(prev), "word moved in low phase");
        was_low = (strobe_n === 1'b0) && sync_n;
        prev = data_out;
    end

    // the run needs about 1220 cycles; over five times that marks a hang
    initial
    begin
        #325000;
        n_errors++;
        summarize();
    end

    initial
    begin
        cyc(4);
        nrst = 1'b1;
        cyc(4);
        resync(1);
        // walk all select pairs; only both low may drive the bus
        for (k = 0; k < 4; k++)
        begin
            sel_req = 2'(k);
            cyc(8);
            cmp(17'(oe), 17'(k == 0), "bus enable");
        end
        sel_req = 2'b00;
        // corners first (clip both ways back to back), then random levels
        for (k = 0; k < 20; k++)
        begin
            seed = lfsr(seed);
            v = (k < 5) ? corner[k] : int'(seed % 16'd5) - 2;
            mod_sample = 4'(v);
            cyc(24);
            cmp({over, got}, expect_word(v), "word or range flag");
        end
        // a frozen sequencer must hold both strobe and word
        power_down_n = 1'b0;
        cyc(8);
        s = strobe_n;
        w = data_out;
        repeat (12)
        begin
            cyc(1);
            cmp({strobe_n, data_out}, {s, w}, "activity in power down");
        end
        power_down_n = 1'b1;
        resync(-1);
        summarize();
    end
endmodule : test_decimating_adc_output_port
